// *** rtl/clock_ratio_meter.sv ***
`timescale 1ns/10ps
`default_nettype none
module clock_ratio_meter (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [meter_pkg::REF_SRC_N-1:0] ref_sources,
  input wire logic [meter_pkg::MSR_SRC_N-1:0] msr_sources,
  input wire logic mode_wr,
  input wire logic wr_ref_enable,
  input wire logic [meter_pkg::REF_SEL_W-1:0] wr_ref_select,
  input wire logic [meter_pkg::MSR_SEL_W-1:0] wr_msr_select,
  input wire logic [meter_pkg::REF_NUM_W-1:0] wr_ref_count,
  input wire logic start_wr,
  input wire logic mask_set_wr,
  input wire logic mask_clr_wr,
  input wire logic pend_clr_wr,
  input wire logic [meter_pkg::IRQ_N-1:0] irq_wdata,
  output logic ref_clock_enable,
  output logic [meter_pkg::REF_SEL_W-1:0] ref_source_select,
  output logic [meter_pkg::MSR_SEL_W-1:0] measured_source_select,
  output logic [meter_pkg::REF_NUM_W-1:0] ref_cycle_count,
  output logic ref_switch_busy,
  output logic meas_busy,
  output logic [meter_pkg::RESULT_W-1:0] result_value,
  output logic [meter_pkg::IRQ_N-1:0] irq_mask,
  output logic [meter_pkg::IRQ_N-1:0] irq_status,
  output logic irq
);
  import meter_pkg::*;

  meter_if ifc();

  meas_state_t state_reg, state_next;
  logic en_reg;
  logic [REF_SEL_W-1:0] ref_sel_reg;
  logic [MSR_SEL_W-1:0] msr_sel_reg;
  logic [REF_NUM_W-1:0] ref_num_reg;
  logic [REF_NUM_W-1:0] num_lat_reg;
  logic [REF_NUM_W-1:0] seen_reg, seen_next;
  logic [RESULT_W-1:0] result_reg;
  logic [IRQ_N-1:0] mask_reg, mask_next;
  logic [IRQ_N-1:0] status_reg, status_next;
  logic [8:0] win_ticks_reg;

  // merge one write into a flag vector; which side wins is the caller's
  function automatic logic [IRQ_N-1:0] merge_bits(
    input logic [IRQ_N-1:0] old,
    input logic [IRQ_N-1:0] set_b,
    input logic [IRQ_N-1:0] clr_b,
    input logic set_wins
  );
    merge_bits = set_wins ? ((old & ~clr_b) | set_b) : ((old | set_b) & ~clr_b);
  endfunction: merge_bits

  // reference switch and edge tally
  ref_switch u_switch (
    .mclk(mclk),
    .rstn(rstn),
    .ref_sources(ref_sources),
    .ms(ifc.sw)
  );

  msr_tally u_tally (
    .mclk(mclk),
    .rstn(rstn),
    .msr_sources(msr_sources),
    .mt(ifc.tally)
  );

  // window bookkeeping
  wire idle = (state_reg == ST_IDLE);
  wire start_ok = start_wr & idle;
  wire [8:0] seen_plus = {1'b0, seen_reg} + 9'h001;
  wire [8:0] num_wide = {1'b0, num_lat_reg};
  // a count of zero behaves as one so the window cannot be empty
  wire win_last = ifc.ref_tick & (seen_plus >= num_wide);
  wire done_evt = (state_reg == ST_LOAD);

  // forward mode writes and tally control
  assign ifc.mode_wr = mode_wr;
  assign ifc.ref_en_w = wr_ref_enable;
  assign ifc.ref_sel_w = wr_ref_select;
  assign ifc.msr_sel = msr_sel_reg;
  // window opens on a reference edge, so a partial period is never counted
  assign ifc.cnt_clear = (state_reg == ST_ARM) & ifc.ref_tick;
  assign ifc.cnt_run = (state_reg == ST_RUN);

  // no halt input exists, so a debug stop never pauses the window
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_ok) begin
          state_next = ST_ARM;
        end
      end
      ST_ARM: begin
        // no timeout: a dead reference leaves this waiting forever
        if (ifc.ref_tick) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (win_last) begin
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  assign seen_next = (state_reg == ST_ARM) ? 8'h00 :
    ((state_reg == ST_RUN && ifc.ref_tick) ? seen_reg + 8'h01 : seen_reg);

  // measurement control and result
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      seen_reg <= 8'h00;
      num_lat_reg <= REF_NUM_RST;
      result_reg <= RESULT_RST;
    end else begin
      state_reg <= state_next;
      seen_reg <= seen_next;
      if (start_ok) begin
        num_lat_reg <= ref_num_reg;
      end
      if (done_evt) begin
        // ratio over the latched count gives the frequency in software
        result_reg <= ifc.cnt_value;
      end
    end
  end

  // mode fields; the enable bit mirrors the last write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      en_reg <= MODE_EN_RST;
      ref_sel_reg <= REF_SEL_RST;
      msr_sel_reg <= MSR_SEL_RST;
      ref_num_reg <= REF_NUM_RST;
    end else if (mode_wr) begin
      en_reg <= wr_ref_enable;
      ref_sel_reg <= wr_ref_select;
      msr_sel_reg <= wr_msr_select;
      ref_num_reg <= wr_ref_count;
    end
  end

  // interrupt flags: disable beats enable, a new event beats a clear
  assign mask_next = merge_bits(mask_reg, mask_set_wr ? irq_wdata : IRQ_RST,
    mask_clr_wr ? irq_wdata : IRQ_RST, 1'b0);

  wire [IRQ_N-1:0] evt_set;
  wire [IRQ_N-1:0] clr_b = pend_clr_wr ? irq_wdata : IRQ_RST;
  assign evt_set[IRQ_DONE] = done_evt;
  assign evt_set[IRQ_RDY] = ifc.ref_ready;
  assign status_next = merge_bits(status_reg, evt_set, clr_b, 1'b1);

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi++) begin: g_flag
      // one pending and one mask flop per source
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          status_reg[gi] <= 1'b0;
          mask_reg[gi] <= 1'b0;
        end else begin
          status_reg[gi] <= status_next[gi];
          mask_reg[gi] <= mask_next[gi];
        end
      end
    end
  endgenerate

  // status and outputs
  assign ref_clock_enable = en_reg;
  assign ref_source_select = ref_sel_reg;
  assign measured_source_select = msr_sel_reg;
  assign ref_cycle_count = ref_num_reg;
  assign ref_switch_busy = ifc.ref_busy;
  assign meas_busy = !idle;
  assign result_value = result_reg;
  assign irq_mask = mask_reg;
  assign irq_status = status_reg;
  assign irq = |(status_reg & mask_reg);

  // checking helper: reference ticks seen since start
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      win_ticks_reg <= 9'h000;
    end else if (start_ok) begin
      win_ticks_reg <= 9'h000;
    end else if (!idle && ifc.ref_tick) begin
      win_ticks_reg <= win_ticks_reg + 9'h001;
    end
  end

  wire [8:0] expect_ticks = ((num_lat_reg == 8'h00) ? 9'h001 : num_wide) + 9'h001;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence start_seq;
    start_wr && idle ##1 meas_busy;
  endsequence

  sequence finish_seq;
    state_reg == ST_RUN && win_last ##1 done_evt ##1 !meas_busy;
  endsequence

  start_busy_a: assert property (start_wr && idle |-> start_seq)
    else $error("start did not raise busy");
  zero_start_a: assert property (!start_wr && idle |=> !meas_busy)
    else $error("busy rose without start");
  finish_a: assert property (state_reg == ST_RUN && win_last |-> finish_seq)
    else $error("busy did not clear after window");
  done_load_a: assert property (
    $fell(meas_busy) |-> status_reg[IRQ_DONE] && result_value == $past(ifc.cnt_value))
    else $error("result or done flag missing at end");
  window_len_a: assert property (done_evt |-> win_ticks_reg == expect_ticks)
    else $error("window length wrong");
  hang_a: assert property (
    meas_busy && !ifc.ref_tick && !done_evt |=> meas_busy)
    else $error("measurement ended without reference edge");
  // interrupt mask and pending flags
  mask_set_a: assert property (
    mask_set_wr && !mask_clr_wr |=> (irq_mask & $past(irq_wdata)) == $past(irq_wdata))
    else $error("enable write did not set mask");
  mask_clr_a: assert property (
    mask_clr_wr |=> (irq_mask & $past(irq_wdata)) == IRQ_RST)
    else $error("disable write did not clear mask");
  sticky_a: assert property (
    irq_status[IRQ_DONE] && !(pend_clr_wr && irq_wdata[IRQ_DONE]) |=> irq_status[IRQ_DONE])
    else $error("pending flag lost without clear");
  irq_hold_a: assert property (
    (irq_status & irq_mask) != IRQ_RST && !pend_clr_wr && !mask_clr_wr |=> irq)
    else $error("request dropped while pending");
  event_wins_a: assert property (
    ifc.ref_ready |=> irq_status[IRQ_RDY])
    else $error("ready event lost");

  // mode fields read back exactly what the last write carried
  mode_echo_a: assert property (
    mode_wr |=> ref_clock_enable == $past(wr_ref_enable) &&
    ref_source_select == $past(wr_ref_select))
    else $error("enable or reference select not written");
  window_fields_a: assert property (
    mode_wr |=> measured_source_select == $past(wr_msr_select) &&
    ref_cycle_count == $past(wr_ref_count))
    else $error("measured select or window length not written");

  // window length is frozen at start, so a mid-run write waits for the next run
  count_latch_a: assert property (
    start_ok |=> num_lat_reg == $past(ref_num_reg))
    else $error("window length not latched at start");
  busy_start_a: assert property (
    start_wr && !idle |=> $stable(num_lat_reg))
    else $error("start while busy disturbed the window");
  result_hold_a: assert property (!done_evt |=> $stable(result_value))
    else $error("result changed outside a load");

  // each pending flag is raised only by its own source
  sequence load_seq;
    done_evt ##1 idle && irq_status[IRQ_DONE];
  endsequence

  load_flag_a: assert property (done_evt |-> load_seq)
    else $error("done flag not raised at load");
  done_source_a: assert property (
    $rose(irq_status[IRQ_DONE]) |-> $past(done_evt))
    else $error("done flag raised without a finished window");
  ready_source_a: assert property (
    $rose(irq_status[IRQ_RDY]) |-> $past(ifc.ref_ready))
    else $error("ready flag raised without a switch event");
  pend_clear_a: assert property (
    pend_clr_wr && irq_wdata[IRQ_RDY] && !ifc.ref_ready |=> !irq_status[IRQ_RDY])
    else $error("ready flag survived its clear");
endmodule: clock_ratio_meter
`default_nettype wire

// *** rtl/meter_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface meter_if;
  import meter_pkg::*;
  // mode write forwarded to the reference switch
  logic mode_wr;
  logic ref_en_w;
  logic [REF_SEL_W-1:0] ref_sel_w;
  // reference switch results
  logic ref_tick;
  logic ref_busy;
  logic ref_ready;
  // edge tally control and result
  logic [MSR_SEL_W-1:0] msr_sel;
  logic cnt_clear;
  logic cnt_run;
  logic [RESULT_W-1:0] cnt_value;

  modport core(output mode_wr, ref_en_w, ref_sel_w, msr_sel, cnt_clear, cnt_run,
    input ref_tick, ref_busy, ref_ready, cnt_value);
  modport sw(input mode_wr, ref_en_w, ref_sel_w, output ref_tick, ref_busy, ref_ready);
  modport tally(input msr_sel, cnt_clear, cnt_run, output cnt_value);
endinterface: meter_if
`default_nettype wire

// *** rtl/meter_pkg.sv ***
package meter_pkg;

  // source counts and field widths
  localparam int REF_SRC_N = 4;
  localparam int MSR_SRC_N = 8;
  localparam int REF_SEL_W = 2;
  localparam int MSR_SEL_W = 3;
  localparam int REF_NUM_W = 8;
  localparam int RESULT_W = 24;

  // interrupt source positions
  localparam int IRQ_N = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RDY = 1;

  // reference edges seen before a switch completes
  localparam logic [1:0] SETTLE_LAST = 2'h1;

  // values after reset, and the tally saturation limit
  localparam logic MODE_EN_RST = 1'h0;
  localparam logic [REF_SEL_W-1:0] REF_SEL_RST = 2'h0;
  localparam logic [MSR_SEL_W-1:0] MSR_SEL_RST = 3'h0;
  localparam logic [REF_NUM_W-1:0] REF_NUM_RST = 8'h00;
  localparam logic [RESULT_W-1:0] RESULT_RST = 24'h00_0000;
  localparam logic [RESULT_W-1:0] COUNT_MAX = 24'hff_ffff;
  localparam logic [IRQ_N-1:0] IRQ_RST = 2'h0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ARM = 4'h2,
    ST_RUN = 4'h4,
    ST_LOAD = 4'h8
  } meas_state_t;

  typedef enum logic [3:0] {
    RS_OFF = 4'h1,
    RS_WAKE = 4'h2,
    RS_ON = 4'h4,
    RS_SLEEP = 4'h8
  } ref_state_t;

endpackage: meter_pkg

// *** rtl/msr_tally.sv ***
`timescale 1ns/10ps
`default_nettype none
module msr_tally (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [meter_pkg::MSR_SRC_N-1:0] msr_sources,
  meter_if.tally mt
);
  import meter_pkg::*;

  logic src_q_reg, src_prev_reg;
  logic [RESULT_W-1:0] count_reg, count_next;

  // measured clock must stay below half of mclk to be counted
  wire msr_edge = src_q_reg & ~src_prev_reg;
  wire can_step = mt.cnt_run & msr_edge & (count_reg != COUNT_MAX);

  // saturate instead of wrapping so an overflow reads as full scale
  assign count_next = mt.cnt_clear ? RESULT_RST :
    (can_step ? count_reg + 24'h00_0001 : count_reg);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      src_q_reg <= 1'h0;
      src_prev_reg <= 1'h0;
      count_reg <= RESULT_RST;
    end else begin
      src_q_reg <= msr_sources[mt.msr_sel];
      src_prev_reg <= src_q_reg;
      count_reg <= count_next;
    end
  end

  assign mt.cnt_value = count_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  count_step_a: assert property (
    can_step && !mt.cnt_clear |=> count_reg == $past(count_reg) + 24'h00_0001)
    else $error("edge not counted");
  count_clear_a: assert property (mt.cnt_clear |=> count_reg == RESULT_RST)
    else $error("tally not cleared");
endmodule: msr_tally
`default_nettype wire

// *** rtl/ref_switch.sv ***
`timescale 1ns/10ps
`default_nettype none
module ref_switch (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [meter_pkg::REF_SRC_N-1:0] ref_sources,
  meter_if.sw ms
);
  import meter_pkg::*;

  ref_state_t state_reg, state_next;
  logic [REF_SEL_W-1:0] sel_reg, sel_next;
  logic [1:0] settle_reg, settle_next;
  logic src_q_reg, src_prev_reg, ready_reg;

  // edges of the selected source; a stopped source gives none
  wire src_edge = src_q_reg & ~src_prev_reg;
  wire settle_done = src_edge & (settle_reg == SETTLE_LAST);
  wire in_switch = (state_reg == RS_WAKE) | (state_reg == RS_SLEEP);

  // selection only taken while off, so a change must pass a full disable
  assign sel_next = (ms.mode_wr & ms.ref_en_w & (state_reg == RS_OFF)) ?
    ms.ref_sel_w : sel_reg;
  assign settle_next = (ms.mode_wr | !in_switch) ? 2'h0 :
    (src_edge ? settle_reg + 2'h1 : settle_reg);

  // every enable write restarts a switch toward the written value
  always_comb begin
    state_next = state_reg;
    if (ms.mode_wr) begin
      state_next = ms.ref_en_w ? RS_WAKE : RS_SLEEP;
    end else if (settle_done && state_reg == RS_WAKE) begin
      state_next = RS_ON;
    end else if (settle_done && state_reg == RS_SLEEP) begin
      state_next = RS_OFF;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= RS_OFF;
      sel_reg <= REF_SEL_RST;
      settle_reg <= 2'h0;
      src_q_reg <= 1'h0;
      src_prev_reg <= 1'h0;
      ready_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      settle_reg <= settle_next;
      src_q_reg <= ref_sources[sel_reg];
      src_prev_reg <= src_q_reg;
      ready_reg <= in_switch & settle_done & !ms.mode_wr;
    end
  end

  assign ms.ref_busy = in_switch;
  assign ms.ref_ready = ready_reg;
  assign ms.ref_tick = (state_reg == RS_ON) & src_edge;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  busy_on_write_a: assert property (ms.mode_wr |=> ms.ref_busy)
    else $error("busy not set after enable write");
  stuck_switch_a: assert property (
    ms.ref_busy && !src_edge && !ms.mode_wr |=> ms.ref_busy)
    else $error("switch finished without a source edge");
  ready_on_fall_a: assert property ($fell(ms.ref_busy) |-> ms.ref_ready)
    else $error("no ready event when busy cleared");
endmodule: ref_switch
`default_nettype wire

// *** tb/clock_ratio_meter_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module clock_ratio_meter_bench;
  import meter_pkg::*;
  logic mclk, rstn, mode_wr, wr_ref_enable, start_wr, mask_set_wr, mask_clr_wr, pend_clr_wr;
  logic [REF_SRC_N-1:0] ref_sources, ref_hold;
  logic [MSR_SRC_N-1:0] msr_sources;
  logic [REF_SEL_W-1:0] wr_ref_select, ref_source_select;
  logic [MSR_SEL_W-1:0] wr_msr_select, measured_source_select;
  logic [REF_NUM_W-1:0] wr_ref_count, ref_cycle_count;
  logic [IRQ_N-1:0] irq_wdata, irq_mask, irq_status;
  logic [RESULT_W-1:0] result_value;
  logic ref_clock_enable, ref_switch_busy, meas_busy, irq;
  int err_total, samples_checked, cyc_n, run_cycles, w, rs, rs2, n;
  // reference model: adopted source, switch on, mask, pending
  int m_ref, m_on, m_mask, m_stat;

  clock_ratio_meter u_dut (.mclk(mclk), .rstn(rstn), .ref_sources(ref_sources),
    .msr_sources(msr_sources), .mode_wr(mode_wr), .wr_ref_enable(wr_ref_enable),
    .wr_ref_select(wr_ref_select), .wr_msr_select(wr_msr_select),
    .wr_ref_count(wr_ref_count), .start_wr(start_wr), .mask_set_wr(mask_set_wr),
    .mask_clr_wr(mask_clr_wr), .pend_clr_wr(pend_clr_wr), .irq_wdata(irq_wdata),
    .ref_clock_enable(ref_clock_enable),
    .ref_source_select(ref_source_select), .measured_source_select(measured_source_select),
    .ref_cycle_count(ref_cycle_count), .ref_switch_busy(ref_switch_busy),
    .meas_busy(meas_busy), .result_value(result_value), .irq_mask(irq_mask),
    .irq_status(irq_status), .irq(irq));

  // 125 MHz
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // source i toggles every i+2 cycles; a held reference models a stopped oscillator
  always @(negedge mclk) begin
    cyc_n <= cyc_n + 1;
    for (int i = 0; i < REF_SRC_N; i++) begin
      if (!ref_hold[i]) ref_sources[i] <= 1'((cyc_n / (i + 2)) % 2);
    end
    for (int j = 0; j < MSR_SRC_N; j++) msr_sources[j] <= 1'((cyc_n / (j + 2)) % 2);
  end

  // hang guard, well above the longest sequence
  always @(posedge mclk) begin
    run_cycles <= run_cycles + 1;
    if (run_cycles == 60000) begin
      err_total++;
      $display("MISMATCH t=%0t run timed out", $time);
      stop_test();
    end
  end

  task automatic check(logic [31:0] got, logic [31:0] exp, string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask: check

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask: stop_test

  task automatic check_irq();
    check(32'({irq_mask, irq_status, irq}),
      32'({m_mask[1:0], m_stat[1:0], |(m_stat & m_mask)}), "irq state");
  endtask: check_irq

  task automatic check_reset();
    check(32'(result_value), 32'(RESULT_RST), "result after reset");
    check(32'({ref_clock_enable, ref_source_select, measured_source_select, ref_cycle_count,
      ref_switch_busy, meas_busy, irq_mask, irq_status, irq}), 32'h0000_0000, "reset outputs");
  endtask: check_reset

  // bounded wait for a busy level to drop; sel 1 watches the measurement
  task automatic wait_idle(logic sel, int lim, output int k);
    k = 0;
    while ((sel ? meas_busy : ref_switch_busy) !== 1'b0 && k < lim) begin
      @(negedge mclk);
      k++;
    end
    check(32'(k < lim), 32'h0000_0001, "busy cleared in time");
  endtask: wait_idle

  // ops bits: mask set, mask clear, pending clear; clear wins over set
  task automatic irq_op(logic [2:0] ops, logic [1:0] d);
    @(negedge mclk);
    {mask_set_wr, mask_clr_wr, pend_clr_wr} = ops;
    irq_wdata = d;
    @(negedge mclk);
    {mask_set_wr, mask_clr_wr, pend_clr_wr} = 3'h0;
    if (ops[2]) m_mask |= d;
    if (ops[1]) m_mask &= ~int'(d);
    if (ops[0]) m_stat &= ~int'(d);
    check_irq();
  endtask: irq_op

  task automatic mode_set(logic en, int r, int ms, int cnt);
    @(negedge mclk);
    mode_wr = 1'b1;
    wr_ref_enable = en;
    wr_ref_select = 2'(r);
    wr_msr_select = 3'(ms);
    wr_ref_count = 8'(cnt);
    @(negedge mclk);
    mode_wr = 1'b0;
    // the switch only adopts a new source on an enable write while it is off
    if (m_on == 0 && en) m_ref = r;
    check(32'({ref_clock_enable, ref_source_select, measured_source_select, ref_cycle_count,
      ref_switch_busy}), 32'({en, 2'(r), 3'(ms), 8'(cnt), 1'b1}), "mode write");
    wait_idle(1'b0, 200, w);
    m_on = en;
    m_stat |= 2;
    // the ready flag lands one cycle after busy drops
    @(negedge mclk);
    check_irq();
  endtask: mode_set

  task automatic measure(int ms, int cnt);
    int ex, d;
    // count 0 runs a one-period window; sync delays allow one edge either way
    ex = ((cnt == 0) ? 1 : cnt) * (m_ref + 2) / (ms + 2);
    @(negedge mclk);
    start_wr = 1'b1;
    @(negedge mclk);
    check(32'(meas_busy), 32'h0000_0001, "start taken");
    @(negedge mclk);
    start_wr = 1'b0;
    wait_idle(1'b1, 2000, w);
    d = int'(result_value) - ex;
    check(32'($isunknown(result_value) || d > 1 || d < -1), 32'h0, "ratio result");
    m_stat |= 1;
    check_irq();
    repeat (3) @(negedge mclk);
    check_irq();
    irq_op(3'b001, 2'h3);
    $display("test measure src %0d count %0d exp %0d done", ms, cnt, ex);
  endtask: measure

  initial begin
    {rstn, mode_wr, wr_ref_enable, start_wr, mask_set_wr, mask_clr_wr, pend_clr_wr} = 7'h00;
    wr_ref_select = '0;
    wr_msr_select = '0;
    wr_ref_count = '0;
    irq_wdata = '0;
    ref_hold = '0;
    ref_sources = '0;
    msr_sources = '0;
    {err_total, samples_checked, cyc_n, run_cycles} = {32'd0, 32'd0, 32'd0, 32'd0};
    {m_ref, m_on, m_mask, m_stat} = {32'd0, 32'd0, 32'd0, 32'd0};
    void'($urandom(89788));
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    check_reset();
    $display("test reset done");
    irq_op(3'b100, 2'h3);
    rs = $urandom_range(0, 3);
    rs2 = (rs + 1) % 4;
    mode_set(1'b1, rs, 0, 4);
    // every measured source, random window lengths, count zero first
    for (int m = 0; m < MSR_SRC_N; m++) begin
      n = (m == 0) ? 0 : $urandom_range(1, 30);
      mode_set(1'b1, rs, m, n);
      measure(m, n);
    end
    // simultaneous set and clear, then a write of zeros
    irq_op(3'b110, 2'h1);
    irq_op(3'b100, 2'h0);
    mode_set(1'b1, rs, 5, 12);
    measure(5, 12);
    irq_op(3'b100, 2'h1);
    $display("test mask done");
    // disable, reselect, enable; then a reselect while on must be ignored
    mode_set(1'b0, rs, 2, 10);
    mode_set(1'b1, rs2, 2, 10);
    measure(2, 10);
    mode_set(1'b1, rs, 2, 10);
    measure(2, 10);
    // reference stops mid window: no completion, no switch
    mode_set(1'b1, rs, 0, 200);
    irq_op(3'b001, 2'h3);
    @(negedge mclk);
    start_wr = 1'b1;
    @(negedge mclk);
    start_wr = 1'b0;
    repeat (20) @(negedge mclk);
    ref_hold[m_ref] = 1'b1;
    repeat (300) @(negedge mclk);
    check(32'({meas_busy, irq_status}), 32'h0000_0004, "stalled measurement");
    mode_wr = 1'b1;
    wr_ref_enable = 1'b0;
    wr_ref_select = 2'(rs2);
    @(negedge mclk);
    mode_wr = 1'b0;
    repeat (200) @(negedge mclk);
    check(32'({ref_switch_busy, ref_source_select}), 32'({1'b1, 2'(rs2)}),
      "stalled switch");
    $display("test stopped reference done");
    // second reset recovers the hung block
    ref_hold = '0;
    rstn = 1'b0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    check_reset();
    {m_ref, m_on, m_mask, m_stat} = {32'd0, 32'd0, 32'd0, 32'd0};
    // software turns the reference off before the bus clock would stop
    mode_set(1'b0, 0, 0, 0);
    $display("test second reset done");
    stop_test();
  end
endmodule: clock_ratio_meter_bench
`default_nettype wire
